// file: logic/clear_sequencer.sv
// walks memory areas issuing clear strobes, skipping retained ones
`timescale 1ns/1ns
`include "mode_ctrl_defines.svh"

module clear_sequencer #(
    parameter int ADDR_W = 15,
    parameter logic [14:0] AREA_SIZE = 15'h7FFF
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_start,
    input wire mode_ctrl_pkg::retain_s i_retain,
    input wire logic i_prog_clear_ok,
    input wire logic [14:0] i_prog_start,
    // result
    output mode_ctrl_pkg::mem_clr_s o_clr,
    output logic o_busy,
    output logic [5:0] o_areas_cleared
);
    logic [2:0] area_q;
    logic [14:0] addr_q;
    logic busy_q;
    logic skip;
    mode_ctrl_pkg::retain_s ret_q;
    logic prog_ok_q;

    // --------------------------------------------------------------------
    // area selection
    // --------------------------------------------------------------------
    always_comb begin
        skip = 1'b0;
        case (area_q)
            `AREA_PROG: skip = !prog_ok_q;
            `AREA_HOLD, `AREA_AUX: skip = ret_q.keep_holding;
            `AREA_TC: skip = ret_q.keep_counter;
            `AREA_DM: skip = ret_q.keep_data_mem;
            default: skip = 1'b0;
        endcase
    end

    // --------------------------------------------------------------------
    // walker
    // --------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_q <= 1'b0;
            area_q <= `AREA_PROG;
            addr_q <= `ADDR_ZERO;
            ret_q <= '0;
            prog_ok_q <= 1'b0;
            o_clr <= '0;
            o_areas_cleared <= '0;
        end else begin
            o_clr.valid <= 1'b0;
            if (i_start && !busy_q) begin
                busy_q <= 1'b1;
                area_q <= `AREA_PROG;
                addr_q <= i_prog_start;  // keeps words below start
                ret_q <= i_retain;
                prog_ok_q <= i_prog_clear_ok;
                o_areas_cleared <= '0;
            end else if (busy_q) begin
                if (!skip) begin
                    o_clr.valid <= 1'b1;
                    o_clr.area <= area_q;
                    o_clr.addr <= addr_q;
                    o_areas_cleared[area_q] <= 1'b1;  // listed on display
                end
                if (skip || addr_q == AREA_SIZE) begin
                    addr_q <= `ADDR_ZERO;
                    if (area_q == `AREA_LAST) begin
                        busy_q <= 1'b0;
                    end else begin
                        area_q <= area_q + 3'h1;
                    end
                end else begin
                    addr_q <= addr_q + 15'h0001;
                end
            end
        end
    end

    assign o_busy = busy_q;

endmodule : clear_sequencer

// file: logic/mode_controller.sv
// operating-mode controller with password gate, beeper and memory clear
//
// Local design decisions: the placing of the registers.
`timescale 1ns/1ns
`include "mode_ctrl_defines.svh"

module mode_controller #(
    parameter int ADDR_W = 15,
    parameter logic [14:0] PROG_SIZE = 15'h7FFF
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // pins from outside
    input wire mode_ctrl_pkg::periph_s i_periph,
    input wire logic [1:0] i_mode_sel,
    input wire logic i_start_in,
    input wire logic i_init_mode_on,
    input wire logic i_mem_write_en,
    input wire logic i_mem_is_rom,
    input wire logic i_lang_sel,
    input wire logic i_op_error,
    // console key stream, same clock
    input wire logic i_key_valid,
    input wire logic [4:0] i_key_code,
    input wire logic [14:0] i_key_addr,
    // terminal instruction from the executing program
    input wire logic i_term_instr,
    // change requests from the console
    input wire logic i_data_write_req,
    input wire logic i_prog_edit_req,
    // status out
    output mode_ctrl_pkg::op_mode_e o_mode,
    output logic o_execute,
    output logic o_pw_prompt,
    output logic o_pw_ok,
    output logic o_key_beep_indicator,
    output logic o_beep,
    output logic o_lang_english,
    output logic o_error,
    output logic o_data_write_ok,
    output logic o_prog_edit_ok,
    output logic o_term_keymap,
    output logic [5:0] o_term_msg_len,
    output logic o_clear_busy,
    output logic [5:0] o_areas_cleared,
    output mode_ctrl_pkg::mem_clr_s o_clr
);
    typedef enum logic [2:0] {
        PW_IDLE,
        PW_WAIT_CLEAR,
        PW_WAIT_ADV,
        PW_WAIT_BLANK,
        PW_DONE
    } pw_e;

    typedef enum logic [2:0] {
        KS_IDLE,
        KS_SHIFT,
        KS_RETAIN,
        KS_ADDR
    } key_e;

    // --------------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------------
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [9:0] pins;
    assign pins = {i_periph.console, i_periph.other, i_mode_sel, i_start_in,
        i_init_mode_on, i_mem_write_en, i_mem_is_rom, i_lang_sel, i_op_error};

    // two flops before any logic reads a pin
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    logic con_s;
    logic oth_s;
    logic [1:0] sel_s;
    logic start_s;
    logic init_on_s;
    logic wen_s;
    logic rom_s;
    logic lang_s;
    logic err_s;
    assign {con_s, oth_s, sel_s, start_s, init_on_s, wen_s, rom_s, lang_s, err_s} = sync2_q;

    // --------------------------------------------------------------------
    // power-up strap sampling
    // --------------------------------------------------------------------
    // wait for the synchroniser to fill before taking straps
    logic [1:0] boot_cnt_q;
    logic booted_q;
    logic con_prev_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_cnt_q <= 2'h0;
            booted_q <= 1'b0;
            con_prev_q <= 1'b0;
        end else begin
            if (!booted_q) begin
                boot_cnt_q <= boot_cnt_q + 2'h1;
                booted_q <= (boot_cnt_q == `BOOT_WAIT);
            end
            con_prev_q <= booted_q ? con_s : 1'b0;
        end
    end
    logic boot_take;
    logic console_attach;
    assign boot_take = !booted_q && (boot_cnt_q == `BOOT_WAIT);
    assign console_attach = booted_q && con_s && !con_prev_q;

    // --------------------------------------------------------------------
    // key decode
    // --------------------------------------------------------------------
    logic k_clear;
    logic k_adv;
    logic k_shift;
    logic k_one;
    logic k_change;
    assign k_clear = i_key_valid && i_key_code == `KEY_CLEAR;
    assign k_adv = i_key_valid && i_key_code == `KEY_DISP_ADV;
    assign k_shift = i_key_valid && i_key_code == `KEY_SHIFT;
    assign k_one = i_key_valid && i_key_code == `KEY_DIGIT1;
    assign k_change = i_key_valid && i_key_code == `KEY_CHANGE;

    // --------------------------------------------------------------------
    // password gate
    // --------------------------------------------------------------------
    pw_e pw_q;
    logic pw_accept;
    assign pw_accept = (pw_q == PW_WAIT_BLANK) && k_clear;
    // prompt on power-up or hot console attach
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pw_q <= PW_IDLE;
        end else begin
            case (pw_q)
                PW_IDLE: if (boot_take) pw_q <= PW_WAIT_CLEAR;
                PW_WAIT_CLEAR: if (k_clear) pw_q <= PW_WAIT_ADV;
                PW_WAIT_ADV: begin
                    if (k_adv) pw_q <= PW_WAIT_BLANK;
                    else if (i_key_valid && !k_clear) pw_q <= PW_WAIT_CLEAR;
                end
                PW_WAIT_BLANK: begin
                    if (k_clear) pw_q <= PW_DONE;
                    else if (i_key_valid) pw_q <= PW_WAIT_CLEAR;
                end
                PW_DONE: if (console_attach) pw_q <= PW_WAIT_CLEAR;
                default: pw_q <= PW_IDLE;
            endcase
        end
    end
    logic pw_ok;
    assign pw_ok = (pw_q == PW_DONE);

    // --------------------------------------------------------------------
    // operating mode
    // --------------------------------------------------------------------
    mode_ctrl_pkg::op_mode_e mode_q;
    mode_ctrl_pkg::op_mode_e sel_mode;
    logic [1:0] sel_prev_q;
    always_comb begin
        case (sel_s)
            `SEL_RUN: sel_mode = mode_ctrl_pkg::MODE_RUN;
            `SEL_MONITOR: sel_mode = mode_ctrl_pkg::MODE_MONITOR;
            default: sel_mode = mode_ctrl_pkg::MODE_PROGRAM;
        endcase
    end

    // attach and detach after boot never alter the mode
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_q <= mode_ctrl_pkg::MODE_PROGRAM;
            sel_prev_q <= `SEL_PROGRAM;
        end else begin
            sel_prev_q <= sel_s;
            if (boot_take) begin
                if (con_s) begin
                    mode_q <= sel_mode;
                end else if (oth_s) begin
                    mode_q <= init_on_s ? mode_ctrl_pkg::MODE_RUN
                                        : mode_ctrl_pkg::MODE_PROGRAM;
                end else begin
                    mode_q <= mode_ctrl_pkg::MODE_RUN;
                end
            end else if (pw_accept) begin
                mode_q <= sel_mode;
            end else if (pw_ok && con_s && sel_s != sel_prev_q) begin
                mode_q <= sel_mode;  // selector live after password
            end else if (pw_ok && (k_change || i_term_instr)) begin
                mode_q <= mode_ctrl_pkg::MODE_TERMINAL;
            end
            // no branch for attach or detach
        end
    end
    logic mode_changed;
    assign mode_changed = pw_accept || (pw_ok && con_s && sel_s != sel_prev_q);

    // --------------------------------------------------------------------
    // console key sequencer: beep toggle and memory clear entry
    // --------------------------------------------------------------------
    key_e ks_q;
    logic beep_window_q;
    logic beep_en_q;
    mode_ctrl_pkg::retain_s retain_q;
    logic clr_start;
    logic clr_refused;
    logic is_prog;
    assign is_prog = (mode_q == mode_ctrl_pkg::MODE_PROGRAM);

    // beep toggle only right after password or selector mode change
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            beep_window_q <= 1'b0;
            beep_en_q <= 1'b1;
        end else begin
            if (mode_changed) begin
                beep_window_q <= 1'b1;
            end else if (beep_window_q && ks_q == KS_SHIFT && k_one) begin
                beep_en_q <= !beep_en_q;
                beep_window_q <= 1'b0;
            end else if (i_key_valid && !k_shift) begin
                beep_window_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ks_q <= KS_IDLE;
            retain_q <= '0;
        end else if (i_key_valid && pw_ok) begin
            case (ks_q)
                KS_IDLE: begin
                    if (k_shift) ks_q <= KS_SHIFT;
                    else if (i_key_code == `KEY_MEM_CLEAR && is_prog) ks_q <= KS_RETAIN;
                    retain_q <= '0;
                end
                KS_SHIFT: ks_q <= KS_IDLE;
                KS_RETAIN: begin
                    case (i_key_code)
                        `KEY_RETAIN_SEL: ks_q <= KS_ADDR;
                        `KEY_HOLDING: retain_q.keep_holding <= 1'b1;
                        `KEY_COUNTER: retain_q.keep_counter <= 1'b1;
                        `KEY_DATA_MEM: retain_q.keep_data_mem <= 1'b1;
                        `KEY_DISP_ADV: ks_q <= KS_IDLE;  // walk launched
                        `KEY_CLEAR: ks_q <= KS_IDLE;
                        default: ks_q <= KS_RETAIN;
                    endcase
                end
                KS_ADDR: ks_q <= KS_IDLE;  // address key starts the walk
                default: ks_q <= KS_IDLE;
            endcase
        end
    end

    // advance or address key launches the clear
    assign clr_start = i_key_valid && pw_ok && is_prog
        && ((ks_q == KS_RETAIN && k_adv) || ks_q == KS_ADDR);
    assign clr_refused = i_key_valid && pw_ok && !is_prog
        && i_key_code == `KEY_MEM_CLEAR;

    // --------------------------------------------------------------------
    // clear sequencer
    // --------------------------------------------------------------------
    logic [14:0] clr_from;
    assign clr_from = (ks_q == KS_ADDR) ? i_key_addr : `ADDR_ZERO;

    clear_sequencer #(
        .ADDR_W(ADDR_W),
        .AREA_SIZE(PROG_SIZE)
    ) u_clear (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_start(clr_start),
        .i_retain(retain_q),
        .i_prog_clear_ok(wen_s && !rom_s),
        .i_prog_start(clr_from),
        .o_clr(o_clr),
        .o_busy(o_clear_busy),
        .o_areas_cleared(o_areas_cleared)
    );

    // --------------------------------------------------------------------
    // permission gates and registered outputs
    // --------------------------------------------------------------------
    logic data_ok;
    logic edit_ok;
    assign data_ok = pw_ok && (mode_q == mode_ctrl_pkg::MODE_MONITOR || is_prog);
    assign edit_ok = pw_ok && is_prog;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mode <= mode_ctrl_pkg::MODE_PROGRAM;
            o_execute <= 1'b0;
            o_pw_prompt <= 1'b0;
            o_pw_ok <= 1'b0;
            o_key_beep_indicator <= 1'b0;
            o_beep <= 1'b0;
            o_lang_english <= 1'b1;
            o_error <= 1'b0;
            o_data_write_ok <= 1'b0;
            o_prog_edit_ok <= 1'b0;
            o_term_keymap <= 1'b0;
            o_term_msg_len <= 6'h00;
        end else begin
            o_mode <= mode_q;
            // monitor runs like run; program never runs
            o_execute <= booted_q && start_s && (mode_q == mode_ctrl_pkg::MODE_RUN
                || mode_q == mode_ctrl_pkg::MODE_MONITOR);
            o_pw_prompt <= booted_q && !pw_ok;
            o_pw_ok <= pw_ok;
            o_key_beep_indicator <= beep_en_q;
            o_beep <= err_s || (beep_en_q && i_key_valid) || o_error;
            o_lang_english <= !lang_s;
            // run refuses all writes, others by mode
            o_error <= (i_data_write_req && !data_ok) || (i_prog_edit_req && !edit_ok)
                || clr_refused;
            o_data_write_ok <= i_data_write_req && data_ok;
            o_prog_edit_ok <= i_prog_edit_req && edit_ok;
            o_term_keymap <= (mode_q == mode_ctrl_pkg::MODE_TERMINAL);
            o_term_msg_len <= (mode_q == mode_ctrl_pkg::MODE_TERMINAL) ? `TERM_MSG_CHARS : 6'h00;
        end
    end

endmodule : mode_controller

// file: pkg/mode_ctrl_defines.svh
// constants for the operating-mode and memory-clear controller
`ifndef MODE_CTRL_DEFINES_SVH
`define MODE_CTRL_DEFINES_SVH

// key codes sent by the console
`define KEY_NONE 5'h00
`define KEY_DIGIT0 5'h01
`define KEY_DIGIT1 5'h02
`define KEY_CLEAR 5'h10
`define KEY_DISP_ADV 5'h11
`define KEY_SHIFT 5'h12
`define KEY_CHANGE 5'h13
`define KEY_RETAIN_SEL 5'h14
`define KEY_HOLDING 5'h15
`define KEY_COUNTER 5'h16
`define KEY_DATA_MEM 5'h17
`define KEY_MEM_CLEAR 5'h18

// mode selector / memory-area encodings
`define SEL_PROGRAM 2'h0
`define SEL_MONITOR 2'h1
`define SEL_RUN 2'h2
`define AREA_PROG 3'h0
`define AREA_IO 3'h1
`define AREA_HOLD 3'h2
`define AREA_AUX 3'h3
`define AREA_DM 3'h4
`define AREA_TC 3'h5
`define AREA_LAST 3'h5
`define ADDR_ZERO 15'h0000

// terminal message length, edges of power-up settling
`define TERM_MSG_CHARS 6'h20
`define BOOT_WAIT 2'h2

`endif

// file: pkg/mode_ctrl_pkg.sv
// types shared by the mode controller and its clear sequencer
package mode_ctrl_pkg;

    typedef enum logic [1:0] {
        MODE_PROGRAM,
        MODE_MONITOR,
        MODE_RUN,
        MODE_TERMINAL
    } op_mode_e;

    // peripheral presence as seen on the attach pins
    typedef struct packed {
        logic console;
        logic other;
    } periph_s;

    // one memory write request toward the memory arrays
    typedef struct packed {
        logic valid;
        logic [2:0] area;
        logic [14:0] addr;
    } mem_clr_s;

    // retention choices for a partial clear
    typedef struct packed {
        logic keep_holding;
        logic keep_counter;
        logic keep_data_mem;
    } retain_s;

endpackage : mode_ctrl_pkg

// file: tb/console_model.sv
// console partner model driving the key stream
`timescale 1ns/1ns
`include "mode_ctrl_defines.svh"

module console_model (
    // clock
    input wire logic i_ref_clk,
    // key stream
    output logic o_key_valid,
    output logic [4:0] o_key_code,
    output logic [14:0] o_key_addr
);
    initial begin
        o_key_valid = 1'b0;
        o_key_code = `KEY_NONE;
        o_key_addr = `ADDR_ZERO;
    end

    // one key a call, then inverted code and address
    task automatic send(input logic [4:0] code, input logic [14:0] addr = 15'h0000);
        @(posedge i_ref_clk);
        o_key_valid <= 1'b1;
        o_key_code <= code;
        o_key_addr <= addr;
        @(posedge i_ref_clk);
        o_key_valid <= 1'b0;
        o_key_code <= ~code;
        o_key_addr <= ~addr;
    endtask : send

    // clear, advance, clear to blank
    task automatic password();
        send(`KEY_CLEAR);
        send(`KEY_DISP_ADV);
        send(`KEY_CLEAR);
    endtask : password
endmodule : console_model

// file: tb/mode_controller_test.sv
// self-checking bench for the mode controller
`timescale 1ns/1ns
`include "mode_ctrl_defines.svh"

module mode_controller_test;
    logic clk, rst_b, start_in, init_on, wr_en, is_rom, lang_sel, op_err;
    logic term_instr, data_req, edit_req, key_valid, execute, pw_prompt, pw_ok;
    logic beep_ind, beep, lang_en, error, data_ok, edit_ok, keymap, busy;
    logic [1:0] mode_sel;
    logic [4:0] key_code;
    logic [14:0] key_addr;
    logic [5:0] msg_len, areas;
    mode_ctrl_pkg::periph_s periph;
    mode_ctrl_pkg::op_mode_e mode;
    mode_ctrl_pkg::mem_clr_s clr;
    int n_errors = 0;
    int compares = 0;
    int seen_err = 0;
    int cnt [8];

    mode_controller #(.PROG_SIZE(15'h0007)) mode_controller_inst (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_periph(periph), .i_mode_sel(mode_sel),
        .i_start_in(start_in), .i_init_mode_on(init_on), .i_mem_write_en(wr_en),
        .i_mem_is_rom(is_rom), .i_lang_sel(lang_sel), .i_op_error(op_err),
        .i_key_valid(key_valid), .i_key_code(key_code), .i_key_addr(key_addr),
        .i_term_instr(term_instr), .i_data_write_req(data_req), .i_prog_edit_req(edit_req),
        .o_mode(mode), .o_execute(execute), .o_pw_prompt(pw_prompt), .o_pw_ok(pw_ok),
        .o_key_beep_indicator(beep_ind), .o_beep(beep), .o_lang_english(lang_en),
        .o_error(error), .o_data_write_ok(data_ok), .o_prog_edit_ok(edit_ok),
        .o_term_keymap(keymap), .o_term_msg_len(msg_len), .o_clear_busy(busy),
        .o_areas_cleared(areas), .o_clr(clr));
    console_model console_model_inst (.i_ref_clk(clk), .o_key_valid(key_valid),
        .o_key_code(key_code), .o_key_addr(key_addr));

    // ----------------------------------------
    // clock, monitors and helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // tally clear writes per area and error pulses
    always @(posedge clk) begin
        if (clr.valid === 1'b1) cnt[clr.area]++;
        if (error === 1'b1) seen_err++;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic do_reset();
        rst_b <= 1'b0;
        settle(6);
        rst_b <= 1'b1;
        settle(6);
    endtask : do_reset

    // one-cycle request; grant looked for over two cycles
    task automatic ask(input logic edit, input logic want, input string what);
        logic got;
        @(posedge clk);
        edit_req <= edit;
        data_req <= !edit;
        @(posedge clk);
        edit_req <= 1'b0;
        data_req <= 1'b0;
        #1 got = edit ? edit_ok : data_ok;
        settle(1);
        got = got | (edit ? edit_ok : data_ok);
        check(got === want, what);
    endtask : ask

    // clear key first, bounded wait for the sweep, compare tallies
    task automatic clear_run(input logic [4:0] k [4], input int exp [6], input logic [5:0] m);
        foreach (cnt[i]) cnt[i] = 0;
        console_model_inst.send(`KEY_MEM_CLEAR);
        foreach (k[i]) console_model_inst.send(k[i], (k[i] == `KEY_DIGIT0) ? 15'h0003 : 15'h0000);
        for (int i = 0; i < 100 && busy !== 1'b1; i++) @(posedge clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
        settle(2);
        for (int i = 0; i < 6; i++) check(cnt[i] == exp[i], "area write count");
        check(areas === m, "cleared area map");
    endtask : clear_run

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        periph = '{console: 1'b1, other: 1'b0};
        {start_in, init_on, wr_en, is_rom, lang_sel, op_err} = 6'h28;
        {term_instr, data_req, edit_req, rst_b} = 4'h0;
        mode_sel = `SEL_PROGRAM;
        do_reset();
        check(mode === mode_ctrl_pkg::MODE_PROGRAM && lang_en === 1'b1, "boot mode");
        check(pw_prompt === 1'b1, "password prompt");
        ask(1'b1, 1'b0, "edit before password");
        console_model_inst.password();
        settle(3);
        check(pw_ok === 1'b1 && beep_ind === 1'b1, "password accepted");
        console_model_inst.send(`KEY_SHIFT);
        console_model_inst.send(`KEY_DIGIT1);
        settle(3);
        check(beep_ind === 1'b0, "key beep off");
        ask(1'b1, 1'b1, "edit in program");
        clear_run('{`KEY_DISP_ADV, `KEY_NONE, `KEY_NONE, `KEY_NONE}, '{8, 8, 8, 8, 8, 8},
            6'h3F);
        clear_run('{`KEY_HOLDING, `KEY_COUNTER, `KEY_RETAIN_SEL, `KEY_DIGIT0},
            '{5, 8, 0, 0, 8, 0}, 6'h13);
        is_rom <= 1'b1;
        clear_run('{`KEY_DISP_ADV, `KEY_NONE, `KEY_NONE, `KEY_NONE}, '{0, 8, 8, 8, 8, 8},
            6'h3E);
        is_rom <= 1'b0;
        op_err <= 1'b1;
        settle(4);
        check(beep === 1'b1, "error beep with key beep off");
        op_err <= 1'b0;
        mode_sel <= `SEL_MONITOR;
        settle(6);
        check(mode === mode_ctrl_pkg::MODE_MONITOR && execute === 1'b1, "monitor");
        ask(1'b0, 1'b1, "value change in monitor");
        seen_err = 0;
        console_model_inst.send(`KEY_MEM_CLEAR);
        console_model_inst.send(`KEY_DISP_ADV);
        settle(3);
        check(busy === 1'b0 && seen_err > 0, "clear refused");
        mode_sel <= `SEL_RUN;
        settle(6);
        check(mode === mode_ctrl_pkg::MODE_RUN && execute === 1'b1, "run executes");
        ask(1'b0, 1'b0, "write in run");
        start_in <= 1'b0;
        settle(6);
        check(execute === 1'b0, "start input off");
        start_in <= 1'b1;
        periph.console <= 1'b0;
        settle(6);
        check(mode === mode_ctrl_pkg::MODE_RUN, "detach keeps mode");
        periph.console <= 1'b1;
        settle(6);
        check(mode === mode_ctrl_pkg::MODE_RUN && pw_prompt === 1'b1, "hot attach");
        console_model_inst.password();
        settle(3);
        term_instr <= 1'b1;
        settle(1);
        term_instr <= 1'b0;
        settle(4);
        check(mode === mode_ctrl_pkg::MODE_TERMINAL && msg_len === 6'h20 && keymap === 1'b1,
            "terminal");
        // cold boot: no peripheral, other with switch off, then on
        for (int k = 0; k < 3; k++) begin
            periph <= '{console: 1'b0, other: (k > 0)};
            init_on <= (k == 2);
            do_reset();
            check(mode === ((k == 1) ? mode_ctrl_pkg::MODE_PROGRAM : mode_ctrl_pkg::MODE_RUN),
                "power-up mode");
        end
        report_and_stop();
    end
endmodule : mode_controller_test

// file: tb/mode_ctrl_props.sv
// concurrent checks on the mode controller ports
`timescale 1ns/1ns
`include "mode_ctrl_defines.svh"

module mode_ctrl_props #(
    parameter logic [14:0] PROG_SIZE = 15'h7FFF
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // watched inputs
    input wire logic i_mem_write_en,
    input wire logic i_mem_is_rom,
    input wire logic i_lang_sel,
    input wire logic i_op_error,
    input wire logic i_data_write_req,
    input wire logic i_prog_edit_req,
    // watched outputs
    input wire mode_ctrl_pkg::op_mode_e o_mode,
    input wire logic o_execute,
    input wire logic o_pw_prompt,
    input wire logic o_beep,
    input wire logic o_lang_english,
    input wire logic o_data_write_ok,
    input wire logic o_prog_edit_ok,
    input wire logic o_term_keymap,
    input wire logic [5:0] o_term_msg_len,
    input wire logic o_clear_busy,
    input wire mode_ctrl_pkg::mem_clr_s o_clr
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    // mode and execute come from one flop edge
    a_prog_no_exec: assert property (o_mode == mode_ctrl_pkg::MODE_PROGRAM
        |-> !o_execute) else $error("executing in program");
    a_clear_prog_only: assert property ($rose(o_clear_busy)
        |-> o_mode == mode_ctrl_pkg::MODE_PROGRAM) else $error("clear outside program");
    a_run_no_write: assert property (i_data_write_req &&
        o_mode == mode_ctrl_pkg::MODE_RUN |=> !o_data_write_ok) else $error("write granted in run");
    a_edit_prog_only: assert property (i_prog_edit_req &&
        o_mode != mode_ctrl_pkg::MODE_PROGRAM |=> !o_prog_edit_ok) else $error("edit outside program");
    a_password_blocks: assert property (o_pw_prompt && i_prog_edit_req
        |=> !o_prog_edit_ok) else $error("edit before password");
    a_error_beeps: assert property ($rose(i_op_error) |-> ##[1:4] o_beep)
        else $error("no beep on error");
    a_lang_english: assert property (!i_lang_sel [*4] |-> o_lang_english)
        else $error("english not selected");
    a_term_message: assert property (o_mode == mode_ctrl_pkg::MODE_TERMINAL
        |-> o_term_msg_len == `TERM_MSG_CHARS && o_term_keymap)
        else $error("terminal message or keymap wrong");
    a_prog_protect: assert property (o_clr.valid && o_clr.area == `AREA_PROG
        |-> i_mem_write_en && !i_mem_is_rom) else $error("protected program cleared");
    a_clear_range: assert property (o_clr.valid |-> $past(o_clear_busy) &&
        o_clr.area <= `AREA_LAST && o_clr.addr <= PROG_SIZE) else $error("clear write out of range");

    // main scenarios reached
    c_clear: cover property ($rose(o_clear_busy));
    c_terminal: cover property (o_mode == mode_ctrl_pkg::MODE_TERMINAL);
    c_execute: cover property (o_execute && o_mode == mode_ctrl_pkg::MODE_RUN);
endmodule : mode_ctrl_props

bind mode_controller mode_ctrl_props #(.PROG_SIZE(PROG_SIZE)) mode_ctrl_props_inst (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_mem_write_en(i_mem_write_en),
    .i_mem_is_rom(i_mem_is_rom), .i_lang_sel(i_lang_sel), .i_op_error(i_op_error),
    .i_data_write_req(i_data_write_req), .i_prog_edit_req(i_prog_edit_req),
    .o_mode(o_mode), .o_execute(o_execute), .o_pw_prompt(o_pw_prompt), .o_beep(o_beep),
    .o_lang_english(o_lang_english), .o_data_write_ok(o_data_write_ok),
    .o_prog_edit_ok(o_prog_edit_ok), .o_term_keymap(o_term_keymap),
    .o_term_msg_len(o_term_msg_len), .o_clear_busy(o_clear_busy), .o_clr(o_clr));
